// ### inc/tps_params.svh
// Constants of the table push and bit shift engine
// Function
// RULE1 - Push inserts word, entries move down one
// RULE2 - Push runs once per enabled scan
// RULE3 - Program loads table length 0..FF first
// RULE4 - Program loads table start word address
// RULE5 - First table word is the fill counter
// RULE6 - Counter zero or over length: no move
// RULE7 - Count flag set when counter is zero
// RULE8 - Count flag also set at full length
// RULE9 - Counter increments by one per push
// RULE10 - Length minus counter pushes then stop
// RULE11 - Program loads the counter, never hardware; the engine writes counter plus one at each push
// RULE12 - Flags valid until scan end or reuse
// RULE13 - Program gates enable with one-shot pulse
// RULE14 - Left shift moves bits toward higher positions
// RULE15 - Right shift moves bits toward lower positions
// RULE16 - Bits cross words as one serial chain
// RULE17 - Table ends discard out, fill zeros
// RULE18 - Right shift: zeros enter last word top
// RULE19 - Program gives shift count in octal
// RULE20 - Table words are sixteen bits wide
// RULE21 - Overflow flag when count exceeds table bits
// RULE22 - Carry flag when last discarded bit one
// RULE23 - Left shift: zeros enter first word bottom
// RULE24 - Pushed word lands after the counter word
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH
// Default widths
`define TPS_AW_DEF 8
`define TPS_DW_DEF 16
`define TPS_BUS_AW 8
// Register byte offsets
`define TPS_OFF_CTRL 8'h00
`define TPS_OFF_SCAN 8'h04
`define TPS_OFF_LEN 8'h08
`define TPS_OFF_BASE 8'h0C
`define TPS_OFF_OPND 8'h10
`define TPS_OFF_STAT 8'h14
`define TPS_OFF_MADR 8'h18
`define TPS_OFF_MDAT 8'h1C
// Control field positions
`define TPS_CTRL_EN 0
`define TPS_CTRL_OP_LO 1
`define TPS_CTRL_OP_HI 2
// Status field positions
`define TPS_STAT_BUSY 0
`define TPS_STAT_CNT 1
`define TPS_STAT_OVF 2
`define TPS_STAT_CRY 3
// Reset values
`define TPS_RST_WORD 16'h0000
`define TPS_RST_BYTE 8'h00
// AXI response codes
`define TPS_RESP_OKAY 2'b00
`define TPS_RESP_SLVERR 2'b10
`endif

// ### inc/tps_pkg.sv
// Types shared by the table push and bit shift engine
package tps_pkg;
	// Operation selected by software
	typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_SHL, OP_SHR} tps_op_e;
	// Engine sequencer states
	typedef enum logic [2:0] {S_IDLE, S_PCHK, S_PMOVE, S_PSRC, S_PCNT, S_SCHK, S_SHIFT} tps_state_e;
endpackage

// ### verilog/tps_axil_slave.sv
// AXI4-Lite slave front end for the table engine
`timescale 1ns/1ps
`include "tps_params.svh"
module tps_axil_slave (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [`TPS_BUS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`TPS_BUS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic regWe,
	output logic [`TPS_BUS_AW-1:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrHit,
	output logic [`TPS_BUS_AW-1:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdHit
);
	logic awHeld_r; // Write address captured
	logic wHeld_r; // Write data captured
	logic rdPend_r; // Read address captured, data next edge

	// Write channels: address and data in either order, response after both
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TPS_RESP_OKAY;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			regWe <= 1'b0;
			wrAddr <= '0;
			wrData <= '0;
			wrStrb <= '0;
		end else begin
			regWe <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				s_axi_awready <= 1'b0;
				wrAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				s_axi_wready <= 1'b0;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
			end
			// Both halves present: commit one register write
			if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
				regWe <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
			end
			// Reopen both channels only once the response is gone
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read channel: one outstanding read, data one edge after address
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `TPS_RESP_OKAY;
			rdPend_r <= 1'b0;
			rdAddr <= '0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				rdPend_r <= 1'b1;
				rdAddr <= s_axi_araddr;
			end
			if (rdPend_r) begin
				rdPend_r <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdHit ? rdData : 32'h0000_0000;
				s_axi_rresp <= rdHit ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ### verilog/tps_engine.sv
// Table push and bit shift engine with its word memory and register file
`timescale 1ns/1ps
`include "tps_params.svh"
module tps_engine #(
	parameter int AW = `TPS_AW_DEF,
	// RULE20 sixteen bit words
	parameter int DW = `TPS_DW_DEF
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [`TPS_BUS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`TPS_BUS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import tps_pkg::*;

	// Bus side handshake results
	logic regWe;
	logic [`TPS_BUS_AW-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wrHit;
	logic [`TPS_BUS_AW-1:0] rdAddr;
	logic [31:0] rdData;
	logic rdHit;

	// Software visible registers
	logic ctrlEn_r; // Rung input level
	tps_op_e ctrlOp_r; // Operation run at each scan
	logic [7:0] len_r; // Table length in words
	logic [AW-1:0] base_r; // Table start word address
	logic [DW-1:0] opnd_r; // Push source word or shift count
	logic [AW-1:0] memAddr_r; // Window pointer into word memory
	logic cntFlag_r; // Table count flag
	logic ovfFlag_r; // Shift overflow flag
	logic carryFlag_r; // Shift carry out flag

	// Working copy of parameters, frozen for one operation
	tps_state_e state_r;
	logic [7:0] wLen_r;
	logic [AW-1:0] wBase_r;
	logic [DW-1:0] wOpnd_r;
	logic wLeft_r; // Shift direction
	logic [DW-1:0] cnt_r; // Fill counter read at push start
	logic [7:0] ptr_r; // Word index inside the table
	logic [DW-1:0] pass_r; // Single bit passes still to do
	logic carry_r; // Bit travelling between words

	// Word memory, no reset: contents are data, not control
	logic [DW-1:0] memA [0:(1<<AW)-1];
	logic engWe;
	logic [AW-1:0] engRdAddr;
	logic [AW-1:0] engWrAddr;
	logic [DW-1:0] engWdata;
	logic [DW-1:0] rdWord;
	logic shOut; // Bit leaving the current word
	logic [DW-1:0] len16; // Length widened for counter compares
	logic [DW-1:0] totBits; // Bits held by the whole table
	logic lastWord; // Current shift word is the far end
	logic scanGo; // Scan boundary accepted
	logic memWrGo; // Bus write into word memory

	// Merge written bytes into a 16 bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] strb);
		merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	tps_axil_slave u_bus (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regWe(regWe),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrHit(wrHit),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdHit(rdHit)
	);

	assign len16 = DW'(wLen_r);
	assign totBits = DW'({wLen_r, 4'h0});
	assign rdWord = memA[engRdAddr];
	assign lastWord = wLeft_r ? (ptr_r == wLen_r - 8'h01) : (ptr_r == 8'h00);
	// Scan writes while busy are dropped so a flag set never meets a clear
	assign scanGo = regWe && (wrAddr == `TPS_OFF_SCAN) && (state_r == S_IDLE);
	assign memWrGo = regWe && (wrAddr == `TPS_OFF_MDAT) && (state_r == S_IDLE);
	// Status is read only, so writes to it are refused
	assign wrHit = (wrAddr <= `TPS_OFF_MDAT) && (wrAddr[1:0] == 2'b00) && (wrAddr != `TPS_OFF_STAT);

	// Control registers written by software
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlEn_r <= 1'b0;
			ctrlOp_r <= OP_NONE;
			len_r <= `TPS_RST_BYTE;
			base_r <= '0;
			opnd_r <= `TPS_RST_WORD;
			memAddr_r <= '0;
		end else if (regWe && wrStrb[0]) begin
			case (wrAddr)
				`TPS_OFF_CTRL: begin
					ctrlEn_r <= wrData[`TPS_CTRL_EN];
					ctrlOp_r <= tps_op_e'(wrData[`TPS_CTRL_OP_HI:`TPS_CTRL_OP_LO]);
				end
				`TPS_OFF_LEN: len_r <= wrData[7:0];
				`TPS_OFF_BASE: base_r <= AW'(merge16(16'(base_r), wrData, wrStrb));
				`TPS_OFF_OPND: opnd_r <= merge16(opnd_r, wrData, wrStrb);
				`TPS_OFF_MADR: memAddr_r <= AW'(merge16(16'(memAddr_r), wrData, wrStrb));
				default: ;
			endcase
		end else if (regWe && wrStrb[1]) begin
			// Upper byte only touches the 16 bit registers
			case (wrAddr)
				`TPS_OFF_OPND: opnd_r <= merge16(opnd_r, wrData, wrStrb);
				default: ;
			endcase
		end
	end

	// Engine memory port: one word read and one word written per cycle
	always_comb begin
		engWe = 1'b0;
		engRdAddr = wBase_r + AW'(ptr_r);
		engWrAddr = engRdAddr;
		engWdata = '0;
		shOut = 1'b0;
		case (state_r)
			// RULE1 entries move down
			S_PMOVE: begin
				engWe = 1'b1;
				engWrAddr = engRdAddr + AW'(1);
				engWdata = rdWord;
			end
			// RULE24 source after counter
			S_PSRC: begin
				engWe = 1'b1;
				engWrAddr = wBase_r + AW'(1);
				engWdata = wOpnd_r;
			end
			// RULE9 counter plus one
			S_PCNT: begin
				engWe = 1'b1;
				engWrAddr = wBase_r;
				engWdata = cnt_r + DW'(1);
			end
			// RULE16 serial bit chain
			S_SHIFT: begin
				engWe = 1'b1;
				if (wLeft_r) begin
					// RULE14 toward higher bits
					engWdata = {rdWord[DW-2:0], carry_r};
					shOut = rdWord[DW-1];
				end else begin
					// RULE15 toward lower bits
					engWdata = {carry_r, rdWord[DW-1:1]};
					shOut = rdWord[0];
				end
			end
			default: ;
		endcase
	end

	// Word memory writes; the engine owns the port while busy
	always_ff @(posedge ref_clk) begin
		if (engWe) begin
			memA[engWrAddr] <= engWdata;
		end else if (memWrGo) begin
			memA[memAddr_r] <= merge16(16'(memA[memAddr_r]), wrData, wrStrb);
		end
	end

	// Operation sequencer, one word per cycle, one bit per shift pass
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= S_IDLE;
			wLen_r <= `TPS_RST_BYTE;
			wBase_r <= '0;
			wOpnd_r <= `TPS_RST_WORD;
			wLeft_r <= 1'b0;
			cnt_r <= `TPS_RST_WORD;
			ptr_r <= 8'h00;
			pass_r <= `TPS_RST_WORD;
			carry_r <= 1'b0;
		end else begin
			case (state_r)
				S_IDLE: begin
					// RULE2 once per enabled scan
					if (scanGo && ctrlEn_r && ctrlOp_r != OP_NONE) begin
						wLen_r <= len_r;
						wBase_r <= base_r;
						wOpnd_r <= opnd_r;
						wLeft_r <= (ctrlOp_r == OP_SHL);
						ptr_r <= 8'h00;
						state_r <= (ctrlOp_r == OP_PUSH) ? S_PCHK : S_SCHK;
					end
				end
				S_PCHK: begin
					// RULE5 first word is counter
					cnt_r <= rdWord;
					// RULE6 RULE10 stop outside range
					if (rdWord == '0 || rdWord >= len16) begin
						state_r <= S_IDLE;
					end else begin
						ptr_r <= rdWord[7:0];
						state_r <= S_PMOVE;
					end
				end
				S_PMOVE: begin
					// Bottom entry first so nothing is overwritten
					if (ptr_r == 8'h01) begin
						state_r <= S_PSRC;
					end else begin
						ptr_r <= ptr_r - 8'h01;
					end
				end
				S_PSRC: state_r <= S_PCNT;
				S_PCNT: state_r <= S_IDLE;
				S_SCHK: begin
					// RULE21 count beyond table
					if (wOpnd_r > totBits || wOpnd_r == '0) begin
						state_r <= S_IDLE;
					end else begin
						pass_r <= wOpnd_r;
						ptr_r <= wLeft_r ? 8'h00 : wLen_r - 8'h01;
						carry_r <= 1'b0;
						state_r <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					carry_r <= shOut;
					if (lastWord) begin
						// RULE17 end bit dropped, zero enters
						carry_r <= 1'b0;
						ptr_r <= wLeft_r ? 8'h00 : wLen_r - 8'h01;
						pass_r <= pass_r - DW'(1);
						if (pass_r == DW'(1)) begin
							state_r <= S_IDLE;
						end
					end else begin
						ptr_r <= wLeft_r ? ptr_r + 8'h01 : ptr_r - 8'h01;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Status flags: cleared at each scan boundary, set by the operation
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cntFlag_r <= 1'b0;
			ovfFlag_r <= 1'b0;
			carryFlag_r <= 1'b0;
		end else begin
			// RULE12 cleared at scan end
			if (scanGo) begin
				cntFlag_r <= 1'b0;
				ovfFlag_r <= 1'b0;
				carryFlag_r <= 1'b0;
			end
			// RULE7 RULE8 zero or full
			if (state_r == S_PCHK) begin
				cntFlag_r <= (rdWord == '0) || (rdWord == len16);
			end
			if (state_r == S_PCNT) begin
				cntFlag_r <= (cnt_r + DW'(1) == len16);
			end
			// RULE21 overflow flag
			if (state_r == S_SCHK) begin
				ovfFlag_r <= (wOpnd_r > totBits);
				carryFlag_r <= 1'b0;
			end
			// RULE22 last discarded bit
			if (state_r == S_SHIFT && lastWord && pass_r == DW'(1)) begin
				carryFlag_r <= shOut;
			end
		end
	end

	// Register read decode
	always_comb begin
		rdData = 32'h0000_0000;
		rdHit = 1'b1;
		case (rdAddr)
			`TPS_OFF_CTRL: rdData = 32'({ctrlOp_r, ctrlEn_r});
			`TPS_OFF_SCAN: rdData = 32'h0000_0000;
			`TPS_OFF_LEN: rdData = 32'(len_r);
			`TPS_OFF_BASE: rdData = 32'(base_r);
			`TPS_OFF_OPND: rdData = 32'(opnd_r);
			`TPS_OFF_STAT: rdData = 32'({carryFlag_r, ovfFlag_r, cntFlag_r, state_r != S_IDLE});
			`TPS_OFF_MADR: rdData = 32'(memAddr_r);
			`TPS_OFF_MDAT: rdData = 32'(memA[memAddr_r]);
			default: rdHit = 1'b0;
		endcase
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	property p_pushStart;
		scanGo && ctrlEn_r && ctrlOp_r == OP_PUSH |=> state_r == S_PCHK ##1 state_r != S_PCHK;
	endproperty
	a_pushStart: assert property (p_pushStart) else $error("push not started on scan"); // RULE2

	property p_noMove;
		state_r == S_PCHK && (rdWord == '0 || rdWord >= len16) |=> state_r == S_IDLE && !$past(engWe);
	endproperty
	a_noMove: assert property (p_noMove) else $error("push moved data with bad counter"); // RULE6

	property p_zeroFlag;
		state_r == S_PCHK && rdWord == '0 |=> cntFlag_r;
	endproperty
	a_zeroFlag: assert property (p_zeroFlag) else $error("count flag missing at zero"); // RULE7

	property p_fullFlag;
		state_r == S_PCNT |=> cntFlag_r == ($past(cnt_r) + DW'(1) == len16);
	endproperty
	a_fullFlag: assert property (p_fullFlag) else $error("count flag wrong at full length"); // RULE8

	property p_count;
		state_r == S_PCNT |=> memA[wBase_r] == $past(cnt_r) + DW'(1);
	endproperty
	a_count: assert property (p_count) else $error("fill counter not incremented"); // RULE9

	property p_top;
		state_r == S_PSRC |=> memA[wBase_r + AW'(1)] == wOpnd_r ##1 memA[wBase_r + AW'(1)] == wOpnd_r;
	endproperty
	a_top: assert property (p_top) else $error("source word not at table top"); // RULE24

	property p_moveDown;
		state_r == S_PMOVE |=> memA[$past(engWrAddr)] == $past(rdWord);
	endproperty
	a_moveDown: assert property (p_moveDown) else $error("entry not moved down"); // RULE1

	property p_scanClear;
		scanGo |=> !ovfFlag_r && !carryFlag_r;
	endproperty
	a_scanClear: assert property (p_scanClear) else $error("flags survive scan boundary"); // RULE12

	property p_ovf;
		state_r == S_SCHK && wOpnd_r > totBits |=> ovfFlag_r && state_r == S_IDLE;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // RULE21

	property p_carry;
		state_r == S_SHIFT && lastWord && pass_r == DW'(1) |=> carryFlag_r == $past(shOut) && state_r == S_IDLE;
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag not last bit out"); // RULE22

	property p_leftZero;
		state_r == S_SHIFT && wLeft_r && ptr_r == 8'h00 |-> engWdata[0] == 1'b0;
	endproperty
	a_leftZero: assert property (p_leftZero) else $error("left shift fill not zero"); // RULE23

	property p_rightZero;
		state_r == S_SHIFT && !wLeft_r && ptr_r == wLen_r - 8'h01 |-> !engWdata[DW-1];
	endproperty
	a_rightZero: assert property (p_rightZero) else $error("right shift fill not zero"); // RULE18

	c_pushDone: cover property (state_r == S_PCNT ##1 cntFlag_r);
	c_ovf: cover property (state_r == S_SCHK ##1 ovfFlag_r);
	c_carry: cover property (state_r == S_SHIFT ##1 carryFlag_r);
	c_memWr: cover property (memWrGo);
endmodule

// ### verif/testbench.sv
// Self-checking bench for the table push and bit shift engine
`timescale 1ns/1ps
`include "tps_params.svh"
module testbench;
	import tps_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic awValid, wValid, bReady, arValid, rReady;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp;
	logic [31:0] rData;
	// Reference copy of the word memory, kept by the bench
	logic [15:0] refMem [0:255];
	logic refFlag, refOvf, refCry;
	logic [15:0] lfsrState = 16'h000C;
	int n_fail = 0;
	int total_checks = 0;

	// Free-running 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	tps_engine DUT (.ref_clk(ref_clk), .arst_n(arst_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

	// Fixed-seed Galois shift register for repeatable stimulus
	function automatic logic [15:0] rnd();
		lfsrState = (lfsrState >> 1) ^ (lfsrState[0] ? 16'hB400 : 16'h0000);
		return lfsrState;
	endfunction

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
		end
	endtask

	// Write cycle: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		logic [1:0] r;
		t = 0;
		@(posedge ref_clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge ref_clk);
			t++;
			if (awValid && awReady === 1'b1) awValid <= 1'b0;
			if (wValid && wReady === 1'b1) wValid <= 1'b0;
		end while (bValid !== 1'b1 && t < 200);
		r = bResp;
		bReady <= 1'b0;
		if (t >= 200) n_fail++;
		chk_resp(r, er, "write response");
	endtask

	// Read cycle: rready held until the data is sampled
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge ref_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge ref_clk);
			t++;
			if (arValid && arReady === 1'b1) arValid <= 1'b0;
		end while (rValid !== 1'b1 && t < 200);
		d = rData;
		rReady <= 1'b0;
		if (t >= 200) n_fail++;
		chk_resp(rResp, er, "read response");
	endtask

	task automatic wr_mem(input logic [7:0] a, input logic [15:0] v);
		axi_wr(`TPS_OFF_MADR, {24'h000000, a}, `TPS_RESP_OKAY);
		axi_wr(`TPS_OFF_MDAT, {16'h0000, v}, `TPS_RESP_OKAY);
		refMem[a] = v;
	endtask

	// Reads the table back word by word against the reference copy
	task automatic cmp_table(input logic [7:0] b, input int n);
		logic [31:0] d;
		logic [7:0] a;
		for (int i = 0; i < n; i++) begin
			a = b + 8'(i);
			axi_wr(`TPS_OFF_MADR, {24'h000000, a}, `TPS_RESP_OKAY);
			axi_rd(`TPS_OFF_MDAT, d, `TPS_RESP_OKAY);
			chk_word({16'h0000, d[15:0]}, {16'h0000, refMem[a]}, "table word");
		end
	endtask

	// One scan with the rung input given, then poll until idle
	task automatic run_op(input tps_op_e op, input logic en, output logic [31:0] st);
		int t;
		t = 0;
		axi_wr(`TPS_OFF_CTRL, {29'h00000000, op, en}, `TPS_RESP_OKAY);
		axi_wr(`TPS_OFF_SCAN, 32'h00000000, `TPS_RESP_OKAY);
		do begin
			axi_rd(`TPS_OFF_STAT, st, `TPS_RESP_OKAY);
			t++;
		end while (st[0] !== 1'b0 && t < 500);
		if (t >= 500) n_fail++;
	endtask

	// Push model: counter word at base, entries slide down, source lands after counter
	function automatic void model_push(input logic [7:0] b, input int len, input logic [15:0] src);
		int c;
		c = refMem[b];
		if (c == 0 || c >= len) begin
			refFlag = (c == 0 || c == len);
		end else begin
			for (int i = c; i >= 1; i--) refMem[8'(b + i + 1)] = refMem[8'(b + i)];
			refMem[8'(b + 1)] = src;
			refMem[b] = 16'(c + 1);
			refFlag = (c + 1 == len);
		end
	endfunction

	// Shift model: the table is one chain, base word at the low end
	function automatic void model_shift(input logic [7:0] b, input int len, input logic left, input int n);
		logic [127:0] v;
		int total;
		total = 16 * len;
		v = '0;
		refOvf = (n > total);
		refCry = 1'b0;
		if (n <= total && n != 0) begin
			for (int k = 0; k < len; k++) v[16*k +: 16] = refMem[8'(b + k)];
			refCry = left ? v[total - n] : v[n - 1];
			v = left ? (v << n) : (v >> n);
			for (int k = 0; k < len; k++) refMem[8'(b + k)] = v[16*k +: 16];
		end
	endfunction

	// Watchdog: far beyond the expected run length
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_fail++;
		finish_test();
	end

	initial begin
		logic [31:0] d, st;
		logic [7:0] base;
		logic [15:0] src;
		int cnt [8];
		{awAddr, arAddr, wData} = '0;
		wStrb = 4'hF;
		{awValid, wValid, bReady, arValid, rReady} = '0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		axi_rd(`TPS_OFF_STAT, d, `TPS_RESP_OKAY);
		chk_word(d, 32'h00000000, "status after reset");
		axi_rd(8'h20, d, `TPS_RESP_SLVERR);
		chk_word(d, 32'h00000000, "unmapped read data");
		axi_rd(8'h02, d, `TPS_RESP_SLVERR);
		axi_wr(`TPS_OFF_STAT, 32'h0000000F, `TPS_RESP_SLVERR);
		// Push: counter 2, length 6, four additions then stop
		base = 8'(rnd());
		axi_wr(`TPS_OFF_LEN, 32'h00000006, `TPS_RESP_OKAY);
		axi_wr(`TPS_OFF_BASE, {24'h000000, base}, `TPS_RESP_OKAY);
		wr_mem(base, 16'h0002);
		for (int i = 1; i < 8; i++) wr_mem(base + 8'(i), rnd());
		for (int s = 0; s < 6; s++) begin
			src = rnd();
			axi_wr(`TPS_OFF_OPND, {16'h0000, src}, `TPS_RESP_OKAY);
			model_push(base, 6, src);
			run_op(OP_PUSH, 1'b1, st);
			chk_flag(st[1], refFlag, "count flag after push");
			cmp_table(base, 8);
		end
		// Counter zero, then counter above length: no move
		foreach (cnt[i]) cnt[i] = 0;
		cnt[1] = 7;
		for (int s = 0; s < 2; s++) begin
			wr_mem(base, 16'(cnt[s]));
			model_push(base, 6, src);
			run_op(OP_PUSH, 1'b1, st);
			chk_flag(st[1], refFlag, "count flag edge");
			cmp_table(base, 8);
		end
		// Rung input off: the scan runs nothing
		wr_mem(base, 16'h0003);
		run_op(OP_PUSH, 1'b0, st);
		chk_flag(st[1], 1'b0, "count flag idle scan");
		cmp_table(base, 8);
		// Shifts over a five-word table, corner counts then a random one
		cnt = '{'o14, 1, 0, 80, 81, 'o17, 16, 0};
		cnt[7] = 2 + int'(rnd() % 16'd78);
		axi_wr(`TPS_OFF_LEN, 32'h00000005, `TPS_RESP_OKAY);
		for (int c = 0; c < 8; c++) begin
			for (int lf = 0; lf < 2; lf++) begin
				for (int k = 0; k < 5; k++) wr_mem(base + 8'(k), rnd());
				axi_wr(`TPS_OFF_OPND, cnt[c], `TPS_RESP_OKAY);
				model_shift(base, 5, lf[0], cnt[c]);
				run_op(lf[0] ? OP_SHL : OP_SHR, 1'b1, st);
				chk_flag(st[2], refOvf, "overflow flag");
				if (!refOvf) chk_flag(st[3], refCry, "carry flag");
				cmp_table(base, 5);
			end
		end
		finish_test();
	end
endmodule
